/* verilog/i2c_slave_map.vh */
// constants for the two-wire slave port: counts, phases, reset values
`ifndef I2C_SLAVE_MAP_VH
`define I2C_SLAVE_MAP_VH

// serial clock edges within one byte
`define LAST_DATA_BIT 4'h8
`define ACK_BIT 4'h9
`define FIRST_SHIFT_BIT 4'h1

// ten-bit address phases
`define PHASE_HIGH 2'h0
`define PHASE_LOW 2'h1
`define PHASE_DONE 2'h2

// reset values
`define CLOCK_RELEASE_RESET 1'b1
`define SLAVE_ADDRESS_RESET 8'h00
`define BUFFER_RESET 8'h00
`define PIN_IDLE_LEVEL 1'b1

// transmit queue shape
`define TX_FIFO_WIDTH 8
`define TX_FIFO_DEPTH 4

`endif

/* verilog/pin_sync.v */
// three-stage input synchroniser with edge pulses
module pin_sync
(
    // clock and reset
    input wire mclk,
    input wire reset,
    // asynchronous pin
    input wire pin,
    // filtered level and edges
    output wire level,
    output wire rise,
    output wire fall
);

`include "i2c_slave_map.vh"

reg s1_reg;
reg s2_reg;
reg s3_reg;
reg level_reg;
reg rise_reg;
reg fall_reg;

assign level = level_reg;
assign rise = rise_reg;
assign fall = fall_reg;

always @(posedge mclk)
begin
    if (reset)
    begin
        s1_reg <= `PIN_IDLE_LEVEL;
        s2_reg <= `PIN_IDLE_LEVEL;
        s3_reg <= `PIN_IDLE_LEVEL;
        level_reg <= `PIN_IDLE_LEVEL;
        rise_reg <= 1'b0;
        fall_reg <= 1'b0;
    end
    else
    begin
        s1_reg <= pin;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        // a change counts once stages two and three agree
        rise_reg <= (s2_reg == s3_reg) && s3_reg && !level_reg;
        fall_reg <= (s2_reg == s3_reg) && !s3_reg && level_reg;
        if (s2_reg == s3_reg)
            level_reg <= s3_reg;
    end
end

endmodule

/* verilog/tx_fifo.v */
// small first-in first-out queue with valid and ready on both sides
module tx_fifo
#(
    parameter WIDTH = 8,
    parameter DEPTH = 4
)
(
    // clock and reset
    input wire mclk,
    input wire reset,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

localparam AW = $clog2(DEPTH);
localparam [AW:0] FULL_COUNT = DEPTH;

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr_reg;
reg [AW-1:0] rd_ptr_reg;
reg [AW:0] count_reg;
reg [AW:0] count_next;
reg in_ready_reg;
reg out_valid_reg;

wire push = in_valid && in_ready_reg;
wire pop = out_valid_reg && out_ready;

assign in_ready = in_ready_reg;
assign out_valid = out_valid_reg;
assign out_data = mem[rd_ptr_reg];

always @*
begin
    count_next = count_reg;
    if (push && !pop)
        count_next = count_reg + 1'b1;
    else if (pop && !push)
        count_next = count_reg - 1'b1;
end

always @(posedge mclk)
begin
    if (push)
        mem[wr_ptr_reg] <= in_data;
end

always @(posedge mclk)
begin
    if (reset)
    begin
        wr_ptr_reg <= {AW{1'b0}};
        rd_ptr_reg <= {AW{1'b0}};
        count_reg <= {(AW+1){1'b0}};
        in_ready_reg <= 1'b0;
        out_valid_reg <= 1'b0;
    end
    else
    begin
        if (push)
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
        if (pop)
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
        count_reg <= count_next;
        in_ready_reg <= (count_next != FULL_COUNT);
        out_valid_reg <= (count_next != {(AW+1){1'b0}});
    end
end

endmodule

/* verilog/i2c_slave.v */
// two-wire slave port: address match, receive, transmit, clock stretching
//
// How it works
// - write-address match clears read flag, buffers address, acknowledges
// - address byte gets no acknowledge while buffer-full or overflow is set
// - interrupt flag set after each byte except a master-nacked one; only software clears it
// - receive with stretching enabled holds clock after a data byte still unread at ninth fall
// - read-address match sets read flag, buffers address, acks; holds clock only if the transmit queue is empty
// - transmit byte loads buffer and shift register together; release follows
// - transmit bits change on falling clock, stable while clock high
// - master nack latched at ninth rise resets slave logic and status
// - acknowledged transmit byte raises interrupt flag at ninth falling clock edge
// - receive with stretching enabled: buffer full at ninth fall clears release bit, holds clock
// - buffer read before ninth fall keeps release bit, no stretch
// - release bit may be set by software at any time
// - ten-bit address phase stretches while update flag set, address write releases
// - update flag set after high address byte and low write byte
// - buffer-full stretching only on data bytes, never address bytes
// - transmit: buffer empty at ninth fall clears release bit, holds clock
// - buffer loaded before ninth fall: no clear, no stretch
// - ten-bit transmit: update flag for two phases, then buffer-full rules
// - clock pulled low only after seen low; held until released
// - bits sampled on rising clock; address compared at eighth fall
module i2c_slave
(
    // clock and reset
    input wire mclk,
    input wire reset,
    // serial clock pin, open drain
    input wire scl_in,
    output wire scl_out,
    output wire scl_oe,
    // serial data pin, open drain
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    // configuration
    input wire ten_bit_mode,
    input wire stretch_enable_bit,
    // slave address register write
    input wire addr_wr,
    input wire [7:0] addr_wdata,
    // transmit bytes into the buffer
    input wire tx_valid,
    input wire [7:0] tx_data,
    output wire tx_ready,
    // received buffer and its read strobe
    input wire rx_read,
    output wire [7:0] serial_data_buffer,
    // status and software controls
    output wire buffer_full_flag,
    output wire receive_overflow_flag,
    input wire overflow_clear,
    output wire port_interrupt_flag,
    input wire interrupt_clear,
    output wire clock_release_bit,
    input wire clock_release_set,
    output wire address_update_flag,
    output wire read_write_flag
);

`include "i2c_slave_map.vh"

localparam ST_IDLE = 4'b0001;
localparam ST_ADDR = 4'b0010;
localparam ST_RX = 4'b0100;
localparam ST_TX = 4'b1000;

function addr_hit;
    input [7:0] shifted;
    input [7:0] addr;
    input whole;
    begin
        if (whole)
            addr_hit = (shifted == addr);
        else
            addr_hit = (shifted[7:1] == addr[7:1]);
    end
endfunction

reg [3:0] state_reg;
reg [3:0] cnt_reg;
reg [7:0] sr_reg;
reg [7:0] tx_sr_reg;
reg [7:0] buf_reg;
reg [7:0] addr_reg;
reg [1:0] phase_reg;
reg bf_reg;
reg ov_reg;
reg rw_reg;
reg ua_reg;
reg int_reg;
reg ckp_reg;
reg ack_reg;
reg drv_reg;
reg pending_reg;
reg addr_byte_reg;
reg ua_hold_reg;
reg scl_oe_reg;
reg sda_oe_reg;

wire scl_lvl;
wire scl_rise;
wire scl_fall;
wire sda_lvl;
wire sda_rise;
wire sda_fall;
wire fifo_valid;
wire [7:0] fifo_data;

wire start_seen = sda_fall && scl_lvl;
wire stop_seen = sda_rise && scl_lvl;
wire busy = (state_reg != ST_IDLE);
wire in_tx = (state_reg == ST_TX);
wire pop = fifo_valid && in_tx && !bf_reg;
wire refuse = bf_reg || ov_reg;
wire long_compare = ten_bit_mode && (phase_reg == `PHASE_LOW);
wire hit = addr_hit(sr_reg, addr_reg, long_compare);
wire hold_want = !ckp_reg || ua_hold_reg;

pin_sync scl_sync
(
    .mclk(mclk),
    .reset(reset),
    .pin(scl_in),
    .level(scl_lvl),
    .rise(scl_rise),
    .fall(scl_fall)
);

pin_sync sda_sync
(
    .mclk(mclk),
    .reset(reset),
    .pin(sda_in),
    .level(sda_lvl),
    .rise(sda_rise),
    .fall(sda_fall)
);

tx_fifo #(.WIDTH(`TX_FIFO_WIDTH), .DEPTH(`TX_FIFO_DEPTH)) tx_queue
(
    .mclk(mclk),
    .reset(reset),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
);

assign scl_out = 1'b0;
assign sda_out = 1'b0;
assign scl_oe = scl_oe_reg;
assign sda_oe = sda_oe_reg;
assign serial_data_buffer = buf_reg;
assign buffer_full_flag = bf_reg;
assign receive_overflow_flag = ov_reg;
assign port_interrupt_flag = int_reg;
assign clock_release_bit = ckp_reg;
assign address_update_flag = ua_reg;
assign read_write_flag = rw_reg;

always @(posedge mclk)
begin
    if (reset)
    begin
        state_reg <= ST_IDLE;
        cnt_reg <= 4'h0;
        sr_reg <= `BUFFER_RESET;
        tx_sr_reg <= `BUFFER_RESET;
        buf_reg <= `BUFFER_RESET;
        addr_reg <= `SLAVE_ADDRESS_RESET;
        phase_reg <= `PHASE_HIGH;
        bf_reg <= 1'b0;
        ov_reg <= 1'b0;
        rw_reg <= 1'b0;
        ua_reg <= 1'b0;
        int_reg <= 1'b0;
        ckp_reg <= `CLOCK_RELEASE_RESET;
        ack_reg <= 1'b0;
        drv_reg <= 1'b0;
        pending_reg <= 1'b0;
        addr_byte_reg <= 1'b0;
        ua_hold_reg <= 1'b0;
        scl_oe_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
    end
    else
    begin
        // software clears first so that hardware sets win
        if (addr_wr)
        begin
            addr_reg <= addr_wdata;
            ua_reg <= 1'b0;
            ua_hold_reg <= 1'b0;
        end
        if (overflow_clear)
            ov_reg <= 1'b0;
        if (interrupt_clear)
            int_reg <= 1'b0;
        if (rx_read && !in_tx)
            bf_reg <= 1'b0;
        if (pop)
        begin
            tx_sr_reg <= fifo_data;
            buf_reg <= fifo_data;
            bf_reg <= 1'b1;
        end
        if (stop_seen)
        begin
            state_reg <= ST_IDLE;
            phase_reg <= `PHASE_HIGH;
            ack_reg <= 1'b0;
            drv_reg <= 1'b0;
            pending_reg <= 1'b0;
        end
        else if (start_seen)
        begin
            state_reg <= ST_ADDR;
            cnt_reg <= 4'h0;
            ack_reg <= 1'b0;
            drv_reg <= 1'b0;
            pending_reg <= 1'b0;
            if (phase_reg != `PHASE_DONE)
                phase_reg <= `PHASE_HIGH;
        end
        else if (scl_rise && busy)
        begin
            if (cnt_reg < `LAST_DATA_BIT)
                sr_reg <= {sr_reg[6:0], sda_lvl};
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == `LAST_DATA_BIT && in_tx && sda_lvl)
            begin
                // master declined the byte
                state_reg <= ST_IDLE;
                rw_reg <= 1'b0;
                ua_reg <= 1'b0;
                bf_reg <= 1'b0;
                pending_reg <= 1'b0;
            end
        end
        else if (scl_fall && busy)
        begin
            if (cnt_reg == `LAST_DATA_BIT)
            begin
                addr_byte_reg <= (state_reg == ST_ADDR);
                drv_reg <= 1'b0;
                pending_reg <= 1'b1;
                if (state_reg == ST_ADDR)
                begin
                    if (!hit)
                    begin
                        state_reg <= ST_IDLE;
                        phase_reg <= `PHASE_HIGH;
                        pending_reg <= 1'b0;
                    end
                    else if (refuse)
                    begin
                        state_reg <= ST_IDLE;
                        int_reg <= 1'b1;
                        pending_reg <= 1'b0;
                    end
                    else
                    begin
                        buf_reg <= sr_reg;
                        rw_reg <= sr_reg[0];
                        ack_reg <= 1'b1;
                        bf_reg <= !sr_reg[0];
                        if (!ten_bit_mode)
                            state_reg <= sr_reg[0] ? ST_TX : ST_RX;
                        else if (phase_reg == `PHASE_LOW)
                        begin
                            // bit zero of the low byte is an address bit, not direction
                            rw_reg <= 1'b0;
                            bf_reg <= 1'b1;
                            ua_reg <= 1'b1;
                            phase_reg <= `PHASE_DONE;
                            state_reg <= ST_RX;
                        end
                        else if (phase_reg == `PHASE_DONE && sr_reg[0])
                            state_reg <= ST_TX;
                        else
                        begin
                            ua_reg <= 1'b1;
                            phase_reg <= `PHASE_LOW;
                        end
                    end
                end
                else if (in_tx)
                    bf_reg <= 1'b0;
                else if (refuse)
                    ov_reg <= ov_reg | bf_reg;
                else
                begin
                    buf_reg <= sr_reg;
                    bf_reg <= 1'b1;
                    ack_reg <= 1'b1;
                end
            end
            else if (cnt_reg == `ACK_BIT)
            begin
                cnt_reg <= 4'h0;
                ack_reg <= 1'b0;
                pending_reg <= 1'b0;
                drv_reg <= in_tx;
                if (pending_reg)
                    int_reg <= 1'b1;
                if (addr_byte_reg && ten_bit_mode && !in_tx)
                    ua_hold_reg <= ua_reg;
                if (addr_byte_reg && !in_tx)
                    ckp_reg <= ckp_reg;
                else if (in_tx && !bf_reg)
                    ckp_reg <= 1'b0;
                else if (!in_tx && stretch_enable_bit && bf_reg)
                    ckp_reg <= 1'b0;
            end
            else if (in_tx && cnt_reg >= `FIRST_SHIFT_BIT)
                tx_sr_reg <= {tx_sr_reg[6:0], 1'b0};
        end
        // software release wins over a same-cycle automatic clear
        if (clock_release_set)
            ckp_reg <= 1'b1;
        // only pull the clock once it is already low
        scl_oe_reg <= hold_want && (scl_oe_reg || !scl_lvl);
        sda_oe_reg <= ack_reg || (drv_reg && bf_reg && !tx_sr_reg[7]);
    end
end

endmodule

/* test/bus_master.sv */
// bus master model driving the open-drain clock and data lines
module bus_master (
    // line levels
    input wire scl_line,
    input wire sda_line,
    // pulls toward low
    output logic scl_low,
    output logic sda_low,
    // stretch outlasted the wait
    output logic stuck
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 320;
    initial
    begin
        scl_low = 0;
        sda_low = 0;
        stuck = 0;
    end
    // release clock, then wait out any slave stretch
    task automatic rise();
        int n;
        n = 0;
        scl_low = 0;
        while (!scl_line && n < 3000)
        begin
            #40;
            n++;
        end
        stuck = !scl_line;
        #T;
    endtask
    // data changes only while clock low, sampled at end of high
    task automatic bit_io(input logic b, output logic r);
        #80 sda_low = !b;
        #T;
        rise();
        r = sda_line;
        scl_low = 1;
    endtask
    task automatic start();
        #80 sda_low = 0;
        #T;
        rise();
        sda_low = 1;
        #T;
        scl_low = 1;
    endtask
    task automatic stop();
        #80 sda_low = 1;
        #T;
        rise();
        sda_low = 0;
        #T;
    endtask
    task automatic wr(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(v[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rd(output logic [7:0] v, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, v[i]);
        bit_io(!ack, r);
    endtask
endmodule

/* test/i2c_slave_chk.sv */
// assertions on the two-wire slave port pins and flags
module i2c_slave_chk (
    // clock and reset
    input wire mclk,
    input wire reset,
    // pins
    input wire scl_in,
    input wire scl_oe,
    input wire sda_oe,
    // controls and flags
    input wire ten_bit_mode,
    input wire buffer_full_flag,
    input wire receive_overflow_flag,
    input wire port_interrupt_flag,
    input wire interrupt_clear,
    input wire clock_release_bit,
    input wire clock_release_set,
    input wire address_update_flag,
    input wire read_write_flag
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    chk_ack_on_rx: assert property (
        $rose(buffer_full_flag) && !read_write_flag |-> ##[1:3] sda_oe) else $error("no ack");
    chk_no_ack_full: assert property (
        $rose(sda_oe) && !read_write_flag |-> !$past(buffer_full_flag, 4) &&
        !receive_overflow_flag) else $error("ack while full");
    chk_irq_sticky: assert property (
        port_interrupt_flag && !interrupt_clear |=> port_interrupt_flag) else $error("irq lost");
    chk_stretch_holds: assert property (
        scl_oe && !clock_release_bit && !clock_release_set |=> scl_oe) else $error("hold lost");
    chk_oe_needs_clear: assert property (
        $rose(scl_oe) && !ten_bit_mode |-> !clock_release_bit) else $error("stray hold");
    chk_release_frees: assert property (
        clock_release_bit && !ten_bit_mode |-> ##[0:2] !scl_oe) else $error("clock kept");
    chk_release_set: assert property (
        clock_release_set |=> clock_release_bit) else $error("release ignored");
    chk_read_ack: assert property (
        $rose(read_write_flag) |-> ##[1:3] sda_oe) else $error("no read ack");
    chk_tx_stable: assert property (
        read_write_flag && scl_in && $past(scl_in) |-> $stable(sda_oe)) else $error("sda moved");
    chk_irq_on_fall: assert property (
        $rose(port_interrupt_flag) |-> !scl_in) else $error("irq off fall");
    chk_nack_idle: assert property (
        $fell(read_write_flag) && !buffer_full_flag |-> !scl_oe && !address_update_flag)
        else $error("not idle");
endmodule
bind i2c_slave i2c_slave_chk i_i2c_slave_chk (.mclk, .reset, .scl_in, .scl_oe, .sda_oe,
    .ten_bit_mode, .buffer_full_flag, .receive_overflow_flag, .port_interrupt_flag,
    .interrupt_clear, .clock_release_bit, .clock_release_set, .address_update_flag,
    .read_write_flag);

/* test/i2c_slave_tb.sv */
// self-checking bench for the two-wire slave port
module i2c_slave_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0;
    logic reset = 1;
    logic ten_bit_mode = 0;
    logic stretch_enable_bit = 0;
    logic [4:0] strobe = 0;
    logic tx_valid = 0;
    logic [7:0] tx_data = 0;
    logic [7:0] addr_wdata = 8'ha0;
    logic [7:0] q [4] = '{8'h5a, 8'hc3, 8'h00, 8'hff};
    logic ack;
    logic [7:0] d;
    int err_count = 0;
    int n_tests = 0;
    wire scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe, m_scl, m_sda, stuck, tx_ready;
    wire buffer_full_flag, receive_overflow_flag, port_interrupt_flag, clock_release_bit;
    wire address_update_flag, read_write_flag;
    wire [7:0] serial_data_buffer;
    // open-drain lines with pull-ups
    assign scl_in = !(m_scl || (scl_oe && !scl_out));
    assign sda_in = !(m_sda || (sda_oe && !sda_out));
    always #20 mclk = ~mclk;
    i2c_slave i_i2c_slave (.mclk, .reset, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe,
        .ten_bit_mode, .stretch_enable_bit, .addr_wr(strobe[4]), .addr_wdata, .tx_valid,
        .tx_data, .tx_ready, .rx_read(strobe[0]), .serial_data_buffer, .buffer_full_flag,
        .receive_overflow_flag, .overflow_clear(strobe[1]), .port_interrupt_flag,
        .interrupt_clear(strobe[2]), .clock_release_bit, .clock_release_set(strobe[3]),
        .address_update_flag, .read_write_flag);
    bus_master i_bus_master (.scl_line(scl_in), .sda_line(sda_in), .scl_low(m_scl),
        .sda_low(m_sda), .stuck);
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // one-cycle software strobes: 0 read, 1 overflow, 2 irq, 3 release, 4 address
    task automatic sw(input logic [4:0] m);
        tick(1);
        strobe = m;
        tick(1);
        strobe = 0;
    endtask
    task automatic push(input logic [7:0] v);
        int n;
        n = 0;
        tick(1);
        tx_valid = 1;
        tx_data = v;
        while (!tx_ready && n < 50)
        begin
            tick(1);
            n++;
        end
        tick(1);
        tx_valid = 0;
        if (n == 50)
        begin
            err_count++;
            close_out();
        end
    endtask
    always @(posedge stuck)
    begin
        err_count++;
        close_out();
    end
    initial
    begin
        tick(4);
        reset = 0;
        tick(6);
        chk({clock_release_bit, scl_oe, port_interrupt_flag, buffer_full_flag}, 4'h8);
        sw(5'h10);
        i_bus_master.start();
        i_bus_master.wr(8'h42, ack);
        chk(ack, 0);
        i_bus_master.stop();
        i_bus_master.start();
        i_bus_master.wr(8'ha0, ack);
        chk({ack, read_write_flag, buffer_full_flag, serial_data_buffer}, 11'h5a0);
        tick(10);
        chk(port_interrupt_flag, 1);
        // unread buffer refuses the data byte
        i_bus_master.wr(8'h3c, ack);
        chk({ack, receive_overflow_flag, serial_data_buffer}, 10'h1a0);
        i_bus_master.stop();
        i_bus_master.start();
        i_bus_master.wr(8'ha0, ack);
        chk(ack, 0);
        i_bus_master.stop();
        sw(5'h07);
        chk({buffer_full_flag, receive_overflow_flag, port_interrupt_flag}, 0);
        stretch_enable_bit = 1;
        i_bus_master.start();
        i_bus_master.wr(8'ha0, ack);
        tick(10);
        chk({ack, clock_release_bit}, 2'h3);
        sw(5'h01);
        i_bus_master.wr(8'h3c, ack);
        tick(10);
        chk({ack, serial_data_buffer, clock_release_bit, scl_oe}, 11'h4f1);
        sw(5'h08);
        tick(2);
        chk({clock_release_bit, scl_oe}, 2'h2);
        sw(5'h01);
        i_bus_master.stop();
        stretch_enable_bit = 0;
        // fill the queue until it refuses, then drain it by reading
        for (int i = 0; i < 4; i++)
            push(q[i]);
        chk(tx_ready, 0);
        i_bus_master.start();
        i_bus_master.wr(8'ha1, ack);
        tick(10);
        chk({ack, read_write_flag, clock_release_bit}, 3'h7);
        for (int i = 0; i < 4; i++)
        begin
            tick(8);
            sw(5'h04);
            i_bus_master.rd(d, i < 3);
            chk(d, q[i]);
            tick(8);
            if (i < 3)
                chk({port_interrupt_flag, clock_release_bit}, 2'h3);
        end
        chk({read_write_flag, buffer_full_flag, sda_oe}, 0);
        i_bus_master.stop();
        // empty queue: read address holds the clock
        i_bus_master.start();
        i_bus_master.wr(8'ha1, ack);
        tick(10);
        chk({ack, clock_release_bit, scl_oe, port_interrupt_flag}, 4'hb);
        push(8'h96);
        tick(4);
        chk({serial_data_buffer, scl_oe}, 9'h12d);
        sw(5'h08);
        i_bus_master.rd(d, 0);
        chk(d, 8'h96);
        i_bus_master.stop();
        // ten-bit addressing: high and low phases, then a read by repeated start
        ten_bit_mode = 1;
        addr_wdata = 8'hf2;
        sw(5'h10);
        i_bus_master.start();
        i_bus_master.wr(8'hf2, ack);
        tick(10);
        chk({ack, address_update_flag, scl_oe, clock_release_bit}, 4'hf);
        addr_wdata = 8'h35;
        sw(5'h11);
        tick(2);
        chk({address_update_flag, scl_oe, buffer_full_flag}, 0);
        i_bus_master.wr(8'h35, ack);
        tick(10);
        chk({ack, address_update_flag, read_write_flag, buffer_full_flag}, 4'hd);
        chk({scl_oe, clock_release_bit}, 2'h3);
        chk(serial_data_buffer, 8'h35);
        addr_wdata = 8'hf2;
        sw(5'h11);
        i_bus_master.wr(8'h77, ack);
        tick(10);
        chk({ack, serial_data_buffer, scl_oe}, 10'h2ee);
        sw(5'h01);
        i_bus_master.start();
        i_bus_master.wr(8'hf3, ack);
        tick(10);
        chk({ack, address_update_flag, read_write_flag}, 3'h5);
        chk({clock_release_bit, scl_oe}, 2'h1);
        push(8'h81);
        sw(5'h08);
        i_bus_master.rd(d, 0);
        chk(d, 8'h81);
        chk({read_write_flag, address_update_flag}, 0);
        i_bus_master.stop();
        ten_bit_mode = 0;
        close_out();
    end
endmodule
